// ---- hdl/nvm_pkg.sv ----
// Shared constants and types for the memory command and protection front end
package nvm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_COMMAND = 4'h0;
	localparam logic [3:0] IDX_PROTECT = 4'h1;
	localparam logic [3:0] IDX_STATUS = 4'h2;
	localparam logic [3:0] IDX_IRQ_EN = 4'h3;
	localparam logic [3:0] IDX_IRQ_FLAG = 4'h4;
	localparam logic [3:0] IDX_FUSE_DATA = 4'h6;
	localparam logic [3:0] IDX_TARGET = 4'h8;
	localparam int AXI_AW = 6;

	// Field positions
	localparam int CMD_LSB = 0;
	localparam int CMD_W = 3;
	localparam int PROT_GUARD_BIT = 0;
	localparam int PROT_LOCK_BIT = 1;
	localparam int ST_FLASH_BIT = 0;
	localparam int ST_EE_BIT = 1;
	localparam int ST_FAULT_BIT = 2;
	localparam int IRQ_EE_IDLE_BIT = 0;

	// Reset values
	localparam logic [2:0] RST_COMMAND = 3'h0;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic RST_BIT = 1'b0;

	// Command codes
	localparam logic [2:0] CMD_NONE = 3'h0;
	localparam logic [2:0] CMD_PAGE_PROGRAM = 3'h1;
	localparam logic [2:0] CMD_PAGE_WIPE = 3'h2;
	localparam logic [2:0] CMD_PAGE_WIPE_AND_PROGRAM = 3'h3;
	localparam logic [2:0] CMD_BUFFER_RESET = 3'h4;
	localparam logic [2:0] CMD_WHOLE_MEMORY_CLEAR = 3'h5;
	localparam logic [2:0] CMD_EEPROM_CLEAR = 3'h6;
	localparam logic [2:0] CMD_FUSE_PROGRAM = 3'h7;

	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int BUFFER_RESET_CYCLES = 7;
	localparam int TIMER_W = 4;
	localparam logic [TIMER_W-1:0] BUFFER_RESET_LOAD = TIMER_W'(BUFFER_RESET_CYCLES - 1);

	// AXI4-Lite responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_AW-1:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	// Request towards the flash/EEPROM arrays
	typedef struct packed {
		logic start;
		logic [2:0] cmd;
		logic to_eeprom;
		logic keep_eeprom;
		logic [15:0] addr;
		logic [15:0] data;
	} arr_req_t;
endpackage

// ---- hdl/nvm_axil_slave.sv ----
// AXI4-Lite slave handshake, one write and one read at a time
`timescale 1ns/100ps
module nvm_axil_slave (
	input wire logic clk, // Clock
	input wire logic rst, // Synchronous reset
	input wire nvm_pkg::axil_req_t req, // Bus request
	output nvm_pkg::axil_rsp_t rsp, // Bus response, registered
	output logic wr_en, // Write strobe to register file
	output logic [nvm_pkg::AXI_AW-1:0] wr_addr, // Write byte address
	output logic [31:0] wr_data, // Write data
	output logic [3:0] wr_strb, // Write byte enables
	input wire logic wr_err, // Write address unmapped
	output logic rd_en, // Read strobe
	output logic [nvm_pkg::AXI_AW-1:0] rd_addr, // Read byte address
	input wire logic [31:0] rd_data, // Read data, same cycle
	input wire logic rd_err // Read address unmapped
);
	import nvm_pkg::*;

	typedef struct packed {
		axil_rsp_t rsp;
		logic aw_have;
		logic w_have;
		logic [AXI_AW-1:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
	} slave_state_t;

	slave_state_t q, d;

	assign rsp = q.rsp;
	assign wr_en = q.aw_have && q.w_have && !q.rsp.bvalid;
	assign wr_addr = q.aw_addr;
	assign wr_data = q.w_data;
	assign wr_strb = q.w_strb;
	assign rd_en = req.arvalid && q.rsp.arready;
	assign rd_addr = req.araddr;

	always_comb begin
		d = q;
		if (req.awvalid && q.rsp.awready) begin
			d.aw_have = 1'b1;
			d.aw_addr = req.awaddr;
			d.rsp.awready = 1'b0;
		end
		if (req.wvalid && q.rsp.wready) begin
			d.w_have = 1'b1;
			d.w_data = req.wdata;
			d.w_strb = req.wstrb;
			d.rsp.wready = 1'b0;
		end
		if (wr_en) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (q.rsp.bvalid && req.bready) begin
			d.rsp.bvalid = 1'b0;
			d.rsp.awready = 1'b1;
			d.rsp.wready = 1'b1;
		end
		if (rd_en) begin
			d.rsp.arready = 1'b0;
			d.rsp.rvalid = 1'b1;
			d.rsp.rdata = rd_err ? 32'h0000_0000 : rd_data;
			d.rsp.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (q.rsp.rvalid && req.rready) begin
			d.rsp.rvalid = 1'b0;
			d.rsp.arready = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
			q.rsp.awready <= 1'b1;
			q.rsp.wready <= 1'b1;
			q.rsp.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end
endmodule

// ---- hdl/nvm_cycle_timer.sv ----
// Down counter that marks the end of a fixed number of cycles
`timescale 1ns/100ps
module nvm_cycle_timer #(
	parameter int W = 4
) (
	input wire logic clk, // Clock
	input wire logic rst, // Synchronous reset
	input wire logic start, // Load and run
	input wire logic [W-1:0] load, // Cycles until done
	output logic busy, // Counting
	output logic done // One-cycle end pulse
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic busy;
		logic done;
	} timer_state_t;

	timer_state_t q, d;

	assign busy = q.busy;
	assign done = q.done;

	always_comb begin
		d = q;
		d.done = 1'b0;
		if (start) begin
			d.cnt = load;
			d.busy = (load != '0);
			d.done = (load == '0);
		end else if (q.busy) begin
			d.cnt = q.cnt - W'(1);
			if (q.cnt == W'(1)) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// ---- hdl/nvm_command_and_protection.sv ----
// Command sequencer, section protection and register file of the memory controller
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
module nvm_command_and_protection #(
	parameter logic [15:0] EE_BASE = 16'h1000,
	parameter logic [15:0] EE_END = 16'h1100,
	parameter logic [15:0] FLASH_BASE = 16'h8000,
	parameter logic [15:0] BOOT_END = 16'h8400,
	parameter logic [15:0] APP_END = 16'ha000,
	parameter int RD_W = 16
) (
	input wire logic CLK, // Clock, 50 MHz
	input wire logic RST, // Synchronous reset, active high
	input wire nvm_pkg::axil_req_t S_AXI_REQ, // AXI4-Lite request
	output nvm_pkg::axil_rsp_t S_AXI_RSP, // AXI4-Lite response
	input wire logic KEY_OPEN, // Unlock window open
	input wire logic DBG_ACCESS, // Current bus access comes from debug port
	input wire logic EXEC_IN_BOOT, // CPU executes inside boot area
	input wire logic KEEP_EEPROM_FUSE, // Keep EEPROM on whole clear
	input wire logic PBUF_MIXED, // Page buffer holds mixed sections
	input wire logic STORE_VALID, // Page buffer store this cycle
	input wire logic [15:0] STORE_ADDR, // Address of that store
	input wire logic ARR_DONE, // Array operation finished
	output nvm_pkg::arr_req_t ARR_REQ, // Array request
	output logic PBUF_CLEAR, // Page buffer fill with ones
	output logic CPU_HALT, // Stall CPU
	output logic BOOT_LOCKED, // Boot area lock active
	input wire logic [15:0] RD_ADDR, // Read or fetch address
	input wire logic [RD_W-1:0] RD_DATA, // Raw array data
	output logic [RD_W-1:0] RD_DATA_OUT, // Filtered data, one cycle later
	output logic IRQ // EEPROM idle interrupt, level
);
	import nvm_pkg::*;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARRAY, SEQ_BUFFER} seq_t;

	typedef struct packed {
		seq_t seq;
		logic [2:0] cmd;
		logic app_guard;
		logic lock_pending;
		logic lock_active;
		logic fl_busy;
		logic ee_busy;
		logic fault;
		logic irq_en;
		logic irq_flag;
		logic [15:0] fuse_data;
		logic [15:0] target;
		arr_req_t arr;
		logic pbuf_clear;
		logic halt;
		logic irq;
		logic [RD_W-1:0] rd_out;
	} top_state_t;

	top_state_t q, d;

	logic wr_en;
	logic [AXI_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [AXI_AW-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	logic tmr_start;
	logic tmr_done;
	logic [3:0] wr_idx;
	logic [3:0] rd_idx;

	function automatic logic idx_mapped(input logic [3:0] idx);
		idx_mapped = (idx == IDX_COMMAND) || (idx == IDX_PROTECT) || (idx == IDX_STATUS) ||
			(idx == IDX_IRQ_EN) || (idx == IDX_IRQ_FLAG) || (idx == IDX_FUSE_DATA) ||
			(idx == IDX_TARGET);
	endfunction

	function automatic logic in_boot(input logic [15:0] a);
		in_boot = (a >= FLASH_BASE) && (a < BOOT_END);
	endfunction

	function automatic logic in_app(input logic [15:0] a);
		in_app = (a >= BOOT_END) && (a < APP_END);
	endfunction

	function automatic logic in_eeprom(input logic [15:0] a);
		in_eeprom = (a >= EE_BASE) && (a < EE_END);
	endfunction

	nvm_axil_slave u_bus (
		.clk(CLK),
		.rst(RST),
		.req(S_AXI_REQ),
		.rsp(S_AXI_RSP),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	nvm_cycle_timer #(
		.W(TIMER_W)
	) u_timer (
		.clk(CLK),
		.rst(RST),
		.start(tmr_start),
		.load(BUFFER_RESET_LOAD),
		.busy(),
		.done(tmr_done)
	);

	assign wr_idx = wr_addr[5:2];
	assign rd_idx = rd_addr[5:2];
	assign wr_err = !idx_mapped(wr_idx);
	assign rd_err = !idx_mapped(rd_idx);

	assign ARR_REQ = q.arr;
	assign PBUF_CLEAR = q.pbuf_clear;
	assign CPU_HALT = q.halt;
	assign BOOT_LOCKED = q.lock_active;
	assign RD_DATA_OUT = q.rd_out;
	assign IRQ = q.irq;

	// Register read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		case (rd_idx)
			IDX_COMMAND: rd_data[CMD_LSB +: CMD_W] = q.cmd;
			IDX_PROTECT: begin
				rd_data[PROT_GUARD_BIT] = q.app_guard;
				rd_data[PROT_LOCK_BIT] = q.lock_pending || q.lock_active;
			end
			IDX_STATUS: begin
				rd_data[ST_FLASH_BIT] = q.fl_busy;
				rd_data[ST_EE_BIT] = q.ee_busy;
				rd_data[ST_FAULT_BIT] = q.fault;
			end
			IDX_IRQ_EN: rd_data[IRQ_EE_IDLE_BIT] = q.irq_en;
			IDX_IRQ_FLAG: rd_data[IRQ_EE_IDLE_BIT] = q.irq_flag;
			IDX_FUSE_DATA: rd_data[15:0] = q.fuse_data;
			IDX_TARGET: rd_data[15:0] = q.target;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_comb begin
		logic [2:0] code;
		logic go;
		logic ee_done;
		logic to_ee;
		logic bad;
		code = wr_data[CMD_LSB +: CMD_W];
		go = 1'b0;
		ee_done = 1'b0;
		to_ee = in_eeprom(q.target);
		bad = 1'b0;
		tmr_start = 1'b0;
		d = q;
		d.arr.start = 1'b0;

		// Command acceptance
		if (wr_en && wr_idx == IDX_COMMAND && wr_strb[0]) begin
			go = (code != CMD_NONE) && KEY_OPEN && (q.seq == SEQ_IDLE) &&
				((code != CMD_FUSE_PROGRAM) || DBG_ACCESS);
		end

		if (go) begin
			d.cmd = code;
			d.fault = 1'b0;
			d.arr.cmd = code;
			d.arr.addr = q.target;
			d.arr.data = q.fuse_data;
			d.arr.keep_eeprom = 1'b0;
			d.arr.to_eeprom = 1'b0;
			case (code)
				CMD_PAGE_PROGRAM, CMD_PAGE_WIPE, CMD_PAGE_WIPE_AND_PROGRAM: begin
					bad = (!to_ee && in_app(q.target) && q.app_guard) ||
						(code != CMD_PAGE_WIPE && PBUF_MIXED);
					if (bad) begin
						d.fault = 1'b1;
						d.cmd = CMD_NONE;
					end else begin
						d.seq = SEQ_ARRAY;
						d.arr.start = 1'b1;
						d.arr.to_eeprom = to_ee;
						d.ee_busy = to_ee;
						d.fl_busy = !to_ee;
						d.halt = !to_ee;
					end
				end
				CMD_BUFFER_RESET: begin
					d.seq = SEQ_BUFFER;
					d.pbuf_clear = 1'b1;
					d.halt = 1'b1;
					tmr_start = 1'b1;
				end
				CMD_WHOLE_MEMORY_CLEAR: begin
					d.seq = SEQ_ARRAY;
					d.arr.start = 1'b1;
					d.arr.keep_eeprom = KEEP_EEPROM_FUSE;
					d.fl_busy = 1'b1;
					d.ee_busy = !KEEP_EEPROM_FUSE;
					d.halt = 1'b1;
				end
				CMD_EEPROM_CLEAR: begin
					d.seq = SEQ_ARRAY;
					d.arr.start = 1'b1;
					d.arr.to_eeprom = 1'b1;
					d.ee_busy = 1'b1;
					d.halt = 1'b1;
				end
				CMD_FUSE_PROGRAM: begin
					d.seq = SEQ_ARRAY;
					d.arr.start = 1'b1;
					d.fl_busy = 1'b1;
				end
				default: d.cmd = CMD_NONE;
			endcase
		end

		// Completion
		case (q.seq)
			SEQ_ARRAY: begin
				if (ARR_DONE) begin
					d.seq = SEQ_IDLE;
					ee_done = q.ee_busy;
					d.ee_busy = 1'b0;
					d.fl_busy = 1'b0;
					d.halt = 1'b0;
					d.cmd = CMD_NONE;
				end
			end
			SEQ_BUFFER: begin
				if (tmr_done) begin
					d.seq = SEQ_IDLE;
					d.pbuf_clear = 1'b0;
					d.halt = 1'b0;
					d.cmd = CMD_NONE;
				end
			end
			SEQ_IDLE: begin
			end
			default: d.seq = SEQ_IDLE;
		endcase

		// Protection bits
		if (wr_en && wr_idx == IDX_PROTECT && wr_strb[0]) begin
			if (wr_data[PROT_GUARD_BIT]) begin
				d.app_guard = 1'b1;
			end
			if (wr_data[PROT_LOCK_BIT] && EXEC_IN_BOOT) begin
				d.lock_pending = 1'b1;
			end
		end
		if (q.lock_pending && !EXEC_IN_BOOT) begin
			d.lock_active = 1'b1;
		end

		// Other registers
		if (wr_en && wr_idx == IDX_IRQ_EN && wr_strb[0]) begin
			d.irq_en = wr_data[IRQ_EE_IDLE_BIT];
		end
		if (wr_en && wr_idx == IDX_IRQ_FLAG && wr_strb[0] && wr_data[IRQ_EE_IDLE_BIT]) begin
			d.irq_flag = 1'b0;
		end
		if (ee_done) begin
			d.irq_flag = 1'b1;
		end
		if (wr_en && wr_idx == IDX_FUSE_DATA) begin
			if (wr_strb[0]) begin
				d.fuse_data[7:0] = wr_data[7:0];
			end
			if (wr_strb[1]) begin
				d.fuse_data[15:8] = wr_data[15:8];
			end
		end
		if (STORE_VALID) begin
			d.target = STORE_ADDR;
		end
		if (wr_en && wr_idx == IDX_TARGET) begin
			if (wr_strb[0]) begin
				d.target[7:0] = wr_data[7:0];
			end
			if (wr_strb[1]) begin
				d.target[15:8] = wr_data[15:8];
			end
		end
		d.irq = d.irq_flag && d.irq_en;

		// Boot area read and fetch filter
		d.rd_out = (q.lock_active && in_boot(RD_ADDR)) ? '0 : RD_DATA;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			q <= '0;
			q.seq <= SEQ_IDLE;
			q.cmd <= RST_COMMAND;
			q.fuse_data <= RST_WORD;
			q.target <= RST_WORD;
			q.app_guard <= RST_BIT;
			q.lock_pending <= RST_BIT;
			q.lock_active <= RST_BIT;
		end else begin
			q <= d;
		end
	end
endmodule

// ---- verification/nvm_command_and_protection_props.sv ----
// Assertion checker for the memory command and protection front end
`timescale 1ns/100ps
module nvm_cap_props #(
	parameter logic [15:0] FLASH_BASE = 16'h8000,
	parameter logic [15:0] BOOT_END = 16'h8400,
	parameter int RD_W = 16
) (
	input wire logic CLK, // Clock
	input wire logic RST, // Reset
	input wire logic DBG_ACCESS, // Debug origin
	input wire logic EXEC_IN_BOOT, // In boot area
	input wire nvm_pkg::arr_req_t ARR_REQ, // Array request
	input wire logic PBUF_CLEAR, // Buffer fill
	input wire logic CPU_HALT, // Stall
	input wire logic BOOT_LOCKED, // Lock active
	input wire logic [15:0] RD_ADDR, // Read address
	input wire logic [RD_W-1:0] RD_DATA_OUT, // Filtered data
	input wire logic IRQ // Interrupt
);
	import nvm_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	property p_buf_len;
		$rose(PBUF_CLEAR) |-> PBUF_CLEAR[*7] ##1 !PBUF_CLEAR;
	endproperty
	a_buf_len: assert property (p_buf_len) else $error("buffer reset length wrong");
	property p_buf_halt;
		PBUF_CLEAR |-> CPU_HALT && !ARR_REQ.start;
	endproperty
	a_buf_halt: assert property (p_buf_halt) else $error("buffer reset without halt");
	property p_start_pulse;
		ARR_REQ.start |=> !ARR_REQ.start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
	property p_fuse_dbg;
		ARR_REQ.start && ARR_REQ.cmd == CMD_FUSE_PROGRAM |-> $past(DBG_ACCESS) && !CPU_HALT;
	endproperty
	a_fuse_dbg: assert property (p_fuse_dbg) else $error("fuse program not from debug");
	property p_ee_nohalt;
		ARR_REQ.start && ARR_REQ.to_eeprom && ARR_REQ.cmd inside {[3'h1:3'h3]} |-> !CPU_HALT;
	endproperty
	a_ee_nohalt: assert property (p_ee_nohalt) else $error("eeprom page op halts");
	property p_lock_zero;
		BOOT_LOCKED && RD_ADDR >= FLASH_BASE && RD_ADDR < BOOT_END |=> RD_DATA_OUT == '0;
	endproperty
	a_lock_zero: assert property (p_lock_zero) else $error("locked read not zero");
	property p_lock_hold;
		BOOT_LOCKED |=> BOOT_LOCKED;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
	property p_lock_leave;
		$rose(BOOT_LOCKED) |-> !$past(EXEC_IN_BOOT);
	endproperty
	a_lock_leave: assert property (p_lock_leave) else $error("lock active inside boot");
	c_buf: cover property ($rose(PBUF_CLEAR));
	c_lock: cover property ($rose(BOOT_LOCKED));
	c_irq: cover property ($rose(IRQ));
endmodule
bind nvm_command_and_protection nvm_cap_props #(.FLASH_BASE(FLASH_BASE),
	.BOOT_END(BOOT_END), .RD_W(RD_W)) u_props (.CLK(CLK), .RST(RST),
	.DBG_ACCESS(DBG_ACCESS), .EXEC_IN_BOOT(EXEC_IN_BOOT), .ARR_REQ(ARR_REQ),
	.PBUF_CLEAR(PBUF_CLEAR), .CPU_HALT(CPU_HALT), .BOOT_LOCKED(BOOT_LOCKED),
	.RD_ADDR(RD_ADDR), .RD_DATA_OUT(RD_DATA_OUT), .IRQ(IRQ));

// ---- verification/nvm_array_model.sv ----
// Array model that ends each request after a set latency
`timescale 1ns/100ps
module nvm_array_model (
	input wire logic CLK, // Clock
	input wire logic RST, // Reset
	input wire nvm_pkg::arr_req_t ARR_REQ, // Request
	input wire logic [7:0] LAT, // Cycles until done, less one
	output logic ARR_DONE // Finish pulse
);
	import nvm_pkg::*;
	logic [7:0] cnt_q;
	logic run_q;
	always_ff @(posedge CLK) begin
		ARR_DONE <= 1'b0;
		if (RST) begin
			run_q <= 1'b0;
			cnt_q <= 8'h00;
		end else if (ARR_REQ.start) begin
			run_q <= 1'b1;
			cnt_q <= LAT;
		end else if (run_q && cnt_q == 8'h00) begin
			run_q <= 1'b0;
			ARR_DONE <= 1'b1;
		end else if (run_q) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule

// ---- verification/nvm_command_and_protection_bench.sv ----
// Self-checking testbench for the memory command and protection front end
`timescale 1ns/100ps
module nvm_command_and_protection_bench;
	import nvm_pkg::*;
	logic clk, halt_s, pbuf, halt, locked, irq, done;
	logic rst = 1'b1, key = 1'b1, dbg = 1'b0, boot = 1'b0, keep = 1'b0, mixed = 1'b0;
	logic [7:0] lat = 8'h14;
	logic [15:0] rd_addr = 16'h0000, rd_data = 16'h0000, rd_out, st_a = 16'h0000;
	logic st_v = 1'b0;
	axil_req_t req = '0;
	axil_rsp_t rsp;
	arr_req_t areq, last;
	int error_cnt = 0, samples_checked = 0, starts = 0, pb_n = 0, cyc = 0;
	nvm_command_and_protection u_dut (.CLK(clk), .RST(rst), .S_AXI_REQ(req), .S_AXI_RSP(rsp),
		.KEY_OPEN(key), .DBG_ACCESS(dbg), .EXEC_IN_BOOT(boot), .KEEP_EEPROM_FUSE(keep),
		.PBUF_MIXED(mixed), .STORE_VALID(st_v), .STORE_ADDR(st_a), .ARR_DONE(done),
		.ARR_REQ(areq), .PBUF_CLEAR(pbuf), .CPU_HALT(halt), .BOOT_LOCKED(locked),
		.RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_DATA_OUT(rd_out), .IRQ(irq));
	nvm_array_model u_array (.CLK(clk), .RST(rst), .ARR_REQ(areq), .LAT(lat), .ARR_DONE(done));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pbuf) pb_n <= pb_n + 1;
		if (areq.start) begin
			starts <= starts + 1;
			last <= areq;
			halt_s <= halt;
		end
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] br;
		b = 1'b0;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		for (int i = 0; i < 40 && !b; i++) begin
			@(negedge clk);
			aw = req.awvalid & rsp.awready;
			w = req.wvalid & rsp.wready;
			b = rsp.bvalid;
			br = rsp.bresp;
			@(posedge clk);
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
		end
		req.bready <= 1'b0;
		chk("write response", {b, br}, {1'b1, er});
	endtask
	task automatic rd(input logic [5:0] a, input logic [1:0] er, output logic [31:0] d);
		logic ar, r;
		logic [1:0] rr;
		r = 1'b0;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (int i = 0; i < 40 && !r; i++) begin
			@(negedge clk);
			ar = req.arvalid & rsp.arready;
			r = rsp.rvalid;
			d = rsp.rdata;
			rr = rsp.rresp;
			@(posedge clk);
			if (ar) req.arvalid <= 1'b0;
		end
		req.rready <= 1'b0;
		chk("read response", {r, rr}, {1'b1, er});
	endtask
	task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		rd(a, er, d);
		chk(nm, d, e);
	endtask
	task automatic idle();
		logic [31:0] d;
		d = 32'h3;
		for (int i = 0; i < 60 && d[1:0] !== 2'b00; i++) rd(6'h08, RESP_OKAY, d);
		chk("status idle", d, 32'h0);
	endtask
	task automatic cmd(input logic [2:0] c, input logic go);
		int s;
		s = starts;
		wr(6'h00, {29'h0, c}, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("starts", starts - s, {31'h0, go});
	endtask
	task automatic op(input logic [2:0] c, input logic [15:0] t, input logic k,
		input logic [1:0] bs, input logic h, input logic e);
		logic [31:0] d;
		wr(6'h20, {16'h0, t}, RESP_OKAY);
		keep <= k;
		cmd(c, 1'b1);
		rd(6'h08, RESP_OKAY, d);
		chk("busy bits", d, {30'h0, bs});
		rc("running code", 6'h00, {29'h0, c}, RESP_OKAY);
		chk("code and halt", {last.cmd, halt_s}, {c, h});
		chk("target", last.addr, t);
		if (c == CMD_WHOLE_MEMORY_CLEAR) chk("keep", last.keep_eeprom, k);
		else chk("eeprom target", last.to_eeprom, e);
		idle();
		chk("halt released", halt, 1'b0);
	endtask
	task automatic t_regs();
		logic [5:0] a [7] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h20};
		foreach (a[i]) rc("reset value", a[i], 32'h0, RESP_OKAY);
		rc("unmapped", 6'h14, 32'h0, RESP_SLVERR);
		wr(6'h3c, 32'hffff_ffff, RESP_SLVERR);
		st_v <= 1'b1;
		st_a <= 16'h1234;
		@(posedge clk);
		st_v <= 1'b0;
		rc("stored target", 6'h20, 32'h1234, RESP_OKAY);
	endtask
	task automatic t_buf();
		int p;
		p = pb_n;
		cmd(CMD_BUFFER_RESET, 1'b0);
		repeat (8) @(posedge clk);
		chk("buffer reset cycles", pb_n - p, 32'h7);
		cmd(CMD_NONE, 1'b0);
		key <= 1'b0;
		cmd(CMD_PAGE_PROGRAM, 1'b0);
		key <= 1'b1;
	endtask
	task automatic t_irq();
		wr(6'h10, 32'h1, RESP_OKAY);
		rc("irq flag cleared", 6'h10, 32'h0, RESP_OKAY);
		wr(6'h0c, 32'h1, RESP_OKAY);
		@(negedge clk);
		chk("irq idle", irq, 1'b0);
		op(CMD_PAGE_WIPE, 16'h1000, 1'b0, 2'b10, 1'b0, 1'b1);
		@(negedge clk);
		chk("irq raised", irq, 1'b1);
		wr(6'h10, 32'h1, RESP_OKAY);
		@(negedge clk);
		chk("irq cleared", irq, 1'b0);
		wr(6'h0c, 32'h0, RESP_OKAY);
		op(CMD_EEPROM_CLEAR, 16'h1000, 1'b0, 2'b10, 1'b1, 1'b1);
		rc("irq flag", 6'h10, 32'h1, RESP_OKAY);
		@(negedge clk);
		chk("irq masked", irq, 1'b0);
	endtask
	task automatic t_fuse();
		wr(6'h18, 32'h1234, RESP_OKAY);
		lat <= 8'h00;
		cmd(CMD_FUSE_PROGRAM, 1'b0);
		dbg <= 1'b1;
		cmd(CMD_FUSE_PROGRAM, 1'b1);
		dbg <= 1'b0;
		chk("fuse", {last.cmd, last.data, halt_s}, {CMD_FUSE_PROGRAM, 16'h1234, 1'b0});
		idle();
		lat <= 8'h14;
	endtask
	task automatic t_guard();
		wr(6'h04, 32'h1, RESP_OKAY);
		wr(6'h04, 32'h0, RESP_OKAY);
		rc("guard bit", 6'h04, 32'h1, RESP_OKAY);
		wr(6'h20, 32'h9000, RESP_OKAY);
		cmd(CMD_PAGE_WIPE, 1'b0);
		rc("guard fault", 6'h08, 32'h4, RESP_OKAY);
		op(CMD_WHOLE_MEMORY_CLEAR, 16'h9000, 1'b1, 2'b01, 1'b1, 1'b0);
		mixed <= 1'b1;
		wr(6'h20, 32'h8100, RESP_OKAY);
		cmd(CMD_PAGE_PROGRAM, 1'b0);
		rc("mixed fault", 6'h08, 32'h4, RESP_OKAY);
		mixed <= 1'b0;
	endtask
	task automatic t_lock();
		wr(6'h04, 32'h2, RESP_OKAY);
		rc("lock from app", 6'h04, 32'h1, RESP_OKAY);
		boot <= 1'b1;
		rd_addr <= 16'h8000;
		rd_data <= 16'habcd;
		wr(6'h04, 32'h2, RESP_OKAY);
		rc("lock pending", 6'h04, 32'h3, RESP_OKAY);
		chk("lock waits", {locked, rd_out}, {1'b0, 16'habcd});
		boot <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("locked read", {locked, rd_out}, {1'b1, 16'h0000});
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rc("after reset", 6'h04, 32'h0, RESP_OKAY);
		chk("lock after reset", locked, 1'b0);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_buf();
		op(CMD_PAGE_PROGRAM, 16'h9000, 1'b0, 2'b01, 1'b1, 1'b0);
		op(CMD_PAGE_WIPE_AND_PROGRAM, 16'h1010, 1'b0, 2'b10, 1'b0, 1'b1);
		op(CMD_PAGE_WIPE_AND_PROGRAM, 16'h8100, 1'b0, 2'b01, 1'b1, 1'b0);
		op(CMD_WHOLE_MEMORY_CLEAR, 16'h0000, 1'b0, 2'b11, 1'b1, 1'b0);
		t_irq();
		t_fuse();
		t_guard();
		t_lock();
		finish_test();
	end
endmodule
